// *** rtl/cim_contact_input_mapper.sv ***
// Purpose: Contact input filtering, function binding and timer/counter
// Assumes: Contact inputs made synchronous-safe via sync stages; time signals arrive already synchronous
// Notes: Registers on a plain port, read data valid one cycle after strobe
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - Timer/counter source: none, eight time signals, channel-2 time signals, inputs.
// R2 - Source none keeps timer/counter idle regardless of inputs.
// R3 - Timer mode: output after input occurs and preset seconds elapse.
// R4 - Counter mode: output when counted activations reach preset count.
// R5 - Timer/counter independent of control state; one-second output pulse.
// R6 - Preset time or count off or 1 to 5000; default off.
// R7 - Input 1 fixed to channel-1 run/reset; inputs 2 to 10 assignable.
// R8 - Every input state readable whether or not assigned.
// R9 - Each function may target channel 1, channel 2 or both.
// R10 - 2/3-bit pattern only on inputs 5, 8; 4/5-bit only on 5.
// R11 - Run/reset is edge detected, unblocked, activation enters run.
// R12 - Forced reset is a level; holds reset while on.
// R13 - Hold is a level; suspends control while on, resumes when off.
// R14 - Advance is edge detected; ignored while hold active.
// R15 - Manual is a level selecting manual output; ignored during autotune.
// R16 - Fixed mode and logic input are levels; logic has no channel.
// R17 - Pattern selects are levels; ignored while fixed mode active.
// R18 - Edge functions toggle: rising edge starts, next rising edge cancels; advance here is a one-cycle pulse per rising edge.
// R19 - A level is accepted only after 0.1 s stable.
// R20 - Panel setting of a function bound to an input is refused.
// R21 - Same function on several inputs per channel: lowest input wins.
// R22 - Multi-terminal pattern assignment clears functions on consumed inputs.
// R23 - Unassigning keeps a running action, except logic input stops.
// R24 - Pattern weights inputs 5..9 as 1..16; needs external select.
// R25 - Decoded pattern zero becomes start pattern 1.
// R26 - Each input passes a two-stage synchroniser before filtering.
module cim_contact_input_mapper #(
  parameter int DEB_CYCLES = cim_pkg::CIM_DEB_CYC,
  parameter int SEC_CYCLES = cim_pkg::CIM_SEC_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [cim_pkg::CIM_NUM_IN-1:0] contact_input,
  input wire logic [cim_pkg::CIM_NUM_TSIG-1:0] time_signal,
  input wire logic [cim_pkg::CIM_NUM_TSIG-1:0] time_signal_ch2,
  input wire logic [cim_pkg::CIM_NUM_CH-1:0] autotune_active,
  input wire logic [cim_pkg::CIM_ADDR_W-1:0] reg_addr,
  input wire logic [cim_pkg::CIM_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [cim_pkg::CIM_DATA_W-1:0] reg_rdata,
  input wire logic panel_set_valid,
  input wire logic [cim_pkg::CIM_FUNC_W-1:0] panel_set_func,
  input wire logic [cim_pkg::CIM_NUM_CH-1:0] panel_set_ch,
  output logic panel_accept,
  output logic panel_reject,
  output logic [cim_pkg::CIM_NUM_CH-1:0] run_active,
  output logic [cim_pkg::CIM_NUM_CH-1:0] force_reset,
  output logic [cim_pkg::CIM_NUM_CH-1:0] hold_control,
  output logic [cim_pkg::CIM_NUM_CH-1:0] program_advance,
  output logic [cim_pkg::CIM_NUM_CH-1:0] fixed_value_mode,
  output logic [cim_pkg::CIM_NUM_CH-1:0] manual_output,
  output logic [cim_pkg::CIM_NUM_IN-1:0] logic_input,
  output logic [cim_pkg::CIM_PTN_W-1:0] start_pattern_ch1,
  output logic [cim_pkg::CIM_PTN_W-1:0] start_pattern_ch2,
  output logic tc_output
);
  import cim_pkg::*;

  localparam int N = CIM_NUM_IN;
  localparam int NC = CIM_NUM_CH;
  localparam int DEB_W = $clog2(DEB_CYCLES + 1);
  localparam int SEC_W = $clog2(SEC_CYCLES + 1);
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYCLES - 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);

  if (DEB_CYCLES < 1 || SEC_CYCLES < 16) begin : g_bad_param
    $error("cim: filter or pulse cycle count too small");
  end

  function automatic logic is_ptn(input cim_func_e f);
    return f inside {CIM_FN_PTN2, CIM_FN_PTN3, CIM_FN_PTN4, CIM_FN_PTN5};
  endfunction

  function automatic logic [2:0] ptn_width(input cim_func_e f);
    case (f)
      CIM_FN_PTN2: ptn_width = 3'h2;
      CIM_FN_PTN3: ptn_width = 3'h3;
      CIM_FN_PTN4: ptn_width = 3'h4;
      CIM_FN_PTN5: ptn_width = 3'h5;
      default: ptn_width = 3'h0;
    endcase
  endfunction

  // Pattern selects are legal only on the two base inputs
  function automatic logic ptn_ok(input int idx, input cim_func_e f);
    if (f == CIM_FN_PTN2 || f == CIM_FN_PTN3) begin
      return idx == CIM_IDX_PTN_A || idx == CIM_IDX_PTN_B;
    end
    if (f == CIM_FN_PTN4 || f == CIM_FN_PTN5) begin
      return idx == CIM_IDX_PTN_A;
    end
    return 1'b1;
  endfunction

  // Input filtering
  logic [N-1:0] sync1_q, sync2_q, deb_q, deb_prev_q, rise_c;
  logic [DEB_W-1:0] deb_cnt_q [N];

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= contact_input; // see R26
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      deb_q <= '0;
      deb_prev_q <= '0;
      for (int i = 0; i < N; i++) begin
        deb_cnt_q[i] <= '0;
      end
    end else begin
      deb_prev_q <= deb_q;
      for (int i = 0; i < N; i++) begin
        if (sync2_q[i] == deb_q[i]) begin
          deb_cnt_q[i] <= '0;
        end else if (deb_cnt_q[i] == DEB_LAST) begin
          deb_q[i] <= sync2_q[i]; // see R19
          deb_cnt_q[i] <= '0;
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign rise_c = deb_q & ~deb_prev_q;

  // Function binding table
  cim_func_e func_q [N];
  logic [NC-1:0] chm_q [N];
  logic [CIM_ADDR_W-1:0] rel_c;
  logic [3:0] idx_c;
  logic func_hit_c, wr_func_ok_c;
  cim_func_e wr_fn_c;

  assign rel_c = reg_addr - CIM_OFF_FUNC_BASE;
  assign idx_c = rel_c[5:2];
  assign func_hit_c = reg_addr >= CIM_OFF_FUNC_BASE &&
                      reg_addr <= CIM_OFF_FUNC_LAST && reg_addr[1:0] == 2'h0;
  assign wr_fn_c = cim_func_e'(reg_wdata[CIM_FUNC_W-1:0]);
  assign wr_func_ok_c = reg_write && func_hit_c && idx_c != 4'h0 && // see R7
                        wr_fn_c <= CIM_FN_PTN5 &&
                        ptn_ok(int'(idx_c), wr_fn_c); // see R10

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) begin
        func_q[i] <= CIM_FN_NONE;
        chm_q[i] <= '0;
      end
      func_q[0] <= CIM_FN_RUN_RESET; // see R7
      chm_q[0] <= CIM_CH1_ONLY;
    end else if (wr_func_ok_c) begin
      func_q[idx_c] <= wr_fn_c;
      // Logic input carries no channel
      chm_q[idx_c] <= (wr_fn_c == CIM_FN_LOGIC) ? '0 : // see R16
        reg_wdata[CIM_FUNC_CH_LSB +: NC]; // see R9
      for (int i = 1; i < N; i++) begin
        if (i > int'(idx_c) && i < int'(idx_c) + int'(ptn_width(wr_fn_c)))
        begin
          func_q[i] <= CIM_FN_NONE; // see R22
          chm_q[i] <= '0;
        end
      end
    end
  end

  // Lowest-numbered input bound to each function per channel
  logic [NC-1:0][CIM_NUM_FN-1:0] win_hit_c, win_lvl_c, win_rise_c;

  always_comb begin
    win_hit_c = '0;
    win_lvl_c = '0;
    win_rise_c = '0;
    for (int c = 0; c < NC; c++) begin
      for (int f = 0; f < CIM_NUM_FN; f++) begin
        for (int i = 0; i < N; i++) begin
          if (!win_hit_c[c][f] && int'(func_q[i]) == f && chm_q[i][c]) begin
            win_hit_c[c][f] = 1'b1; // see R21
            win_lvl_c[c][f] = deb_q[i];
            win_rise_c[c][f] = rise_c[i];
          end
        end
      end
    end
  end

  // Channel control actions
  logic [NC-1:0] run_q, force_q, hold_q, advance_q, fix_q, manual_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      run_q <= '0;
      force_q <= '0;
      hold_q <= '0;
      advance_q <= '0;
      fix_q <= '0;
      manual_q <= '0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        // Level registers keep their value once unbound
        if (win_hit_c[c][CIM_FN_FORCE_RESET]) begin
          force_q[c] <= win_lvl_c[c][CIM_FN_FORCE_RESET]; // see R12 R23
        end
        if (win_hit_c[c][CIM_FN_HOLD]) begin
          hold_q[c] <= win_lvl_c[c][CIM_FN_HOLD]; // see R13
        end
        if (win_hit_c[c][CIM_FN_FIX]) begin
          fix_q[c] <= win_lvl_c[c][CIM_FN_FIX]; // see R16
        end
        if (win_hit_c[c][CIM_FN_MANUAL] && !autotune_active[c]) begin
          manual_q[c] <= win_lvl_c[c][CIM_FN_MANUAL]; // see R15
        end
        advance_q[c] <= win_rise_c[c][CIM_FN_ADVANCE] && !hold_q[c]; // see R14
        if (force_q[c]) begin
          run_q[c] <= 1'b0; // see R12
        end else if (win_rise_c[c][CIM_FN_RUN_RESET]) begin
          run_q[c] <= ~run_q[c]; // see R11 R18
        end
      end
    end
  end

  // Logic input follows its terminal only while bound
  logic [N-1:0] logic_q;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      logic_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        logic_q[i] <= deb_q[i] && func_q[i] == CIM_FN_LOGIC; // see R23
      end
    end
  end

  // Start pattern selection
  logic xsel_q;
  logic [NC-1:0] ptn_hit_c;
  logic [NC-1:0][CIM_PTN_W-1:0] ptn_raw_c;
  logic [NC-1:0][CIM_PTN_W-1:0] ptn_q;

  always_comb begin
    int base;
    cim_func_e fn;
    base = 0;
    fn = CIM_FN_NONE;
    ptn_hit_c = '0;
    ptn_raw_c = '0;
    for (int c = 0; c < NC; c++) begin
      fn = CIM_FN_NONE;
      base = 0;
      if (is_ptn(func_q[CIM_IDX_PTN_A]) && chm_q[CIM_IDX_PTN_A][c]) begin
        fn = func_q[CIM_IDX_PTN_A]; // see R21
        base = CIM_IDX_PTN_A;
      end else if (is_ptn(func_q[CIM_IDX_PTN_B]) &&
                   chm_q[CIM_IDX_PTN_B][c]) begin
        fn = func_q[CIM_IDX_PTN_B];
        base = CIM_IDX_PTN_B;
      end
      ptn_hit_c[c] = fn != CIM_FN_NONE;
      for (int k = 0; k < CIM_PTN_W; k++) begin
        if (k < int'(ptn_width(fn)) && base + k < N) begin
          ptn_raw_c[c][k] = deb_q[base + k]; // see R24
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ptn_q <= {NC{CIM_PTN_RESET}};
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (xsel_q && !fix_q[c] && ptn_hit_c[c]) begin // see R17 R24
          if (ptn_raw_c[c] == '0) begin
            ptn_q[c] <= CIM_PTN_RESET; // see R25
          end else if (ptn_raw_c[c] > CIM_PTN_MAX) begin
            ptn_q[c] <= CIM_PTN_MAX;
          end else begin
            ptn_q[c] <= ptn_raw_c[c];
          end
        end
      end
    end
  end

  // Timer/counter
  logic [CIM_SRC_W-1:0] tc_src_q;
  logic tc_mode_q;
  logic [CIM_PRESET_W-1:0] tc_preset_q, tc_elapsed_q, tc_count_q;
  logic [SEC_W-1:0] sec_cnt_q, pulse_cnt_q;
  logic sec_tick_q, src_lvl_c, src_prev_q, src_rise_c, tc_fire_q, tc_out_q;
  logic tc_off_c;
  cim_tc_state_e tc_state_q;

  always_comb begin
    src_lvl_c = 1'b0; // see R1
    if (tc_src_q >= CIM_SRC_TS1 && tc_src_q <= CIM_SRC_TS8) begin
      src_lvl_c = time_signal[3'(tc_src_q - CIM_SRC_TS1)];
    end else if (tc_src_q >= CIM_SRC_TS1_C2 && tc_src_q <= CIM_SRC_TS8_C2)
    begin
      src_lvl_c = time_signal_ch2[3'(tc_src_q - CIM_SRC_TS1_C2)];
    end else if (tc_src_q >= CIM_SRC_IN1 && tc_src_q <= CIM_SRC_IN10) begin
      src_lvl_c = deb_q[4'(tc_src_q - CIM_SRC_IN1)];
    end
  end

  assign src_rise_c = src_lvl_c && !src_prev_q;
  assign tc_off_c = tc_src_q == CIM_SRC_NONE || tc_preset_q == CIM_PRESET_OFF;

  // One-second tick, free running
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sec_cnt_q <= '0;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= sec_cnt_q == SEC_LAST;
      sec_cnt_q <= (sec_cnt_q == SEC_LAST) ? '0 : sec_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      src_prev_q <= 1'b0;
      tc_state_q <= CIM_TC_IDLE;
      tc_elapsed_q <= '0;
      tc_count_q <= '0;
      tc_fire_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl_c;
      tc_fire_q <= 1'b0;
      if (tc_off_c) begin
        tc_state_q <= CIM_TC_IDLE; // see R2 R6
        tc_elapsed_q <= '0;
        tc_count_q <= '0;
      end else if (!tc_mode_q) begin
        case (tc_state_q)
          CIM_TC_IDLE: begin
            if (src_rise_c) begin
              tc_state_q <= CIM_TC_ARMED;
              tc_elapsed_q <= '0;
            end
          end
          CIM_TC_ARMED: begin
            if (sec_tick_q) begin
              if (tc_elapsed_q + 1'b1 >= tc_preset_q) begin
                tc_fire_q <= 1'b1; // see R3
                tc_state_q <= CIM_TC_IDLE;
              end else begin
                tc_elapsed_q <= tc_elapsed_q + 1'b1;
              end
            end
          end
          default: tc_state_q <= CIM_TC_IDLE;
        endcase
      end else if (src_rise_c) begin
        if (tc_count_q + 1'b1 >= tc_preset_q) begin
          tc_fire_q <= 1'b1; // see R4
          tc_count_q <= '0;
        end else begin
          tc_count_q <= tc_count_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tc_out_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (tc_src_q == CIM_SRC_NONE) begin
      tc_out_q <= 1'b0; // see R2
      pulse_cnt_q <= '0;
    end else if (tc_fire_q) begin
      tc_out_q <= 1'b1; // see R5
      pulse_cnt_q <= SEC_LAST;
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - 1'b1;
    end else begin
      tc_out_q <= 1'b0;
    end
  end

  // Front panel requests
  logic panel_bound_c, panel_acc_q, panel_rej_q;

  always_comb begin
    panel_bound_c = 1'b0;
    if (panel_set_func == CIM_FN_LOGIC) begin
      for (int i = 0; i < N; i++) begin
        panel_bound_c = panel_bound_c || func_q[i] == CIM_FN_LOGIC;
      end
    end else if (int'(panel_set_func) < CIM_NUM_FN) begin
      for (int c = 0; c < NC; c++) begin
        panel_bound_c = panel_bound_c ||
          (panel_set_ch[c] && win_hit_c[c][panel_set_func]);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      panel_acc_q <= 1'b0;
      panel_rej_q <= 1'b0;
    end else begin
      panel_acc_q <= panel_set_valid && !panel_bound_c;
      panel_rej_q <= panel_set_valid && panel_bound_c; // see R20
    end
  end

  // Register writes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      xsel_q <= 1'b0;
      tc_src_q <= CIM_SRC_NONE;
      tc_mode_q <= 1'b0;
      tc_preset_q <= CIM_PRESET_OFF;
    end else if (reg_write) begin
      if (reg_addr == CIM_OFF_CTRL) begin
        xsel_q <= reg_wdata[CIM_CTRL_XSEL_BIT];
      end
      if (reg_addr == CIM_OFF_TC_CFG &&
          reg_wdata[CIM_SRC_W-1:0] <= CIM_SRC_IN10) begin
        tc_src_q <= reg_wdata[CIM_SRC_W-1:0];
        tc_mode_q <= reg_wdata[CIM_TC_MODE_BIT];
      end
      if (reg_addr == CIM_OFF_TC_PRESET &&
          reg_wdata[CIM_DATA_W-1:0] <= 32'(CIM_PRESET_MAX)) begin
        tc_preset_q <= reg_wdata[CIM_PRESET_W-1:0]; // see R6
      end
    end
  end

  // Register reads, data valid only the cycle after the strobe
  logic [CIM_DATA_W-1:0] rdata_q;

  always_ff @(posedge clock) begin
    if (!rst_b || !reg_read) begin
      rdata_q <= '0;
    end else if (reg_addr == CIM_OFF_INPUTS) begin
      rdata_q <= 32'(deb_q); // see R8
    end else if (reg_addr == CIM_OFF_CTRL) begin
      rdata_q <= 32'(xsel_q);
    end else if (reg_addr == CIM_OFF_TC_CFG) begin
      rdata_q <= 32'({tc_mode_q, 3'h0, tc_src_q});
    end else if (reg_addr == CIM_OFF_TC_PRESET) begin
      rdata_q <= 32'(tc_preset_q);
    end else if (reg_addr == CIM_OFF_STATE) begin
      rdata_q <= 32'({tc_out_q, manual_q, fix_q, hold_q, force_q, run_q});
    end else if (func_hit_c) begin
      rdata_q <= 32'({chm_q[idx_c], func_q[idx_c]});
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign panel_accept = panel_acc_q;
  assign panel_reject = panel_rej_q;
  assign run_active = run_q;
  assign force_reset = force_q;
  assign hold_control = hold_q;
  assign program_advance = advance_q;
  assign fixed_value_mode = fix_q;
  assign manual_output = manual_q;
  assign logic_input = logic_q;
  assign start_pattern_ch1 = ptn_q[0];
  assign start_pattern_ch2 = ptn_q[1];
  assign tc_output = tc_out_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_run_edge;
    win_rise_c[0][CIM_FN_RUN_RESET] && !force_q[0];
  endsequence

  sequence s_tc_fire;
    tc_fire_q && tc_src_q != CIM_SRC_NONE;
  endsequence

  chk_run_toggle: assert property ( // see R11
    s_run_edge |=> run_q[0] != $past(run_q[0]))
    else $error("run state did not toggle on edge");
  chk_force_reset: assert property ( // see R12
    force_q[0] |=> !run_q[0])
    else $error("run active during forced reset");
  chk_advance_hold: assert property ( // see R14
    hold_q[0] |=> !advance_q[0])
    else $error("advance issued while holding");
  chk_manual_autotune: assert property ( // see R15
    autotune_active[0] |=> manual_q[0] == $past(manual_q[0]))
    else $error("manual changed during autotune");
  chk_input1_fixed: assert property ( // see R7
    func_q[0] == CIM_FN_RUN_RESET && chm_q[0] == CIM_CH1_ONLY)
    else $error("input 1 binding changed");
  chk_ptn_legal: assert property ( // see R10
    !is_ptn(func_q[1]) && !is_ptn(func_q[5]) && !is_ptn(func_q[9]) &&
    !(func_q[CIM_IDX_PTN_B] inside {CIM_FN_PTN4, CIM_FN_PTN5}))
    else $error("pattern select on illegal input");
  chk_ptn_nonzero: assert property ( // see R25
    ptn_q[0] != '0 && ptn_q[1] != '0)
    else $error("start pattern zero");
  chk_tc_none: assert property ( // see R2
    tc_src_q == CIM_SRC_NONE |=> !tc_output && !tc_fire_q)
    else $error("timer/counter active with no source");
  chk_pulse_width: assert property ( // see R5
    s_tc_fire ##1 tc_src_q != CIM_SRC_NONE [*8] |-> tc_out_q [*8])
    else $error("output pulse too short");
  chk_deb_stable: assert property ( // see R19
    deb_q[0] != $past(deb_q[0]) |-> $past(deb_cnt_q[0]) == DEB_LAST)
    else $error("input accepted before filter time");
  chk_panel_reject: assert property ( // see R20
    panel_set_valid && panel_bound_c |=> panel_reject && !panel_accept)
    else $error("panel request on bound function accepted");
endmodule
`default_nettype wire

// *** include/cim_pkg.sv ***
// Purpose: Shared constants for the contact input function mapper
// Assumes: 125 MHz system clock, ten contact inputs, two control channels
// Notes: Register offsets are byte addresses on the plain register port
`default_nettype none
package cim_pkg;
  localparam int CIM_NUM_IN = 10;
  localparam int CIM_NUM_TSIG = 8;
  localparam int CIM_NUM_CH = 2;
  localparam int CIM_NUM_FN = 12;
  localparam int CIM_ADDR_W = 8;
  localparam int CIM_DATA_W = 32;
  localparam int CIM_FUNC_W = 4;
  localparam int CIM_SRC_W = 5;
  localparam int CIM_PRESET_W = 13;
  localparam int CIM_PTN_W = 5;

  // Timing
  localparam longint CIM_CLK_HZ = 125000000;
  localparam longint CIM_DEB_MS = 100;
  localparam longint CIM_PULSE_S = 1;
  localparam int CIM_DEB_CYC = int'((CIM_CLK_HZ * CIM_DEB_MS) / 1000);
  localparam int CIM_SEC_CYC = int'(CIM_CLK_HZ * CIM_PULSE_S);

  // Register offsets
  localparam logic [7:0] CIM_OFF_INPUTS = 8'h00;
  localparam logic [7:0] CIM_OFF_CTRL = 8'h04;
  localparam logic [7:0] CIM_OFF_TC_CFG = 8'h08;
  localparam logic [7:0] CIM_OFF_TC_PRESET = 8'h0c;
  localparam logic [7:0] CIM_OFF_STATE = 8'h10;
  localparam logic [7:0] CIM_OFF_FUNC_BASE = 8'h20;
  localparam logic [7:0] CIM_OFF_FUNC_LAST = 8'h44;

  // Field positions
  localparam int CIM_CTRL_XSEL_BIT = 0;
  localparam int CIM_TC_MODE_BIT = 8;
  localparam int CIM_FUNC_CH_LSB = 4;

  // Values and limits
  localparam logic [12:0] CIM_PRESET_OFF = 13'h0000;
  localparam logic [12:0] CIM_PRESET_MAX = 13'h1388;
  localparam logic [4:0] CIM_PTN_MAX = 5'h14;
  localparam logic [4:0] CIM_PTN_RESET = 5'h01;
  localparam logic [1:0] CIM_CH1_ONLY = 2'h1;
  localparam int CIM_IDX_PTN_A = 4;
  localparam int CIM_IDX_PTN_B = 7;

  // Timer/counter source codes
  localparam logic [4:0] CIM_SRC_NONE = 5'h00;
  localparam logic [4:0] CIM_SRC_TS1 = 5'h01;
  localparam logic [4:0] CIM_SRC_TS8 = 5'h08;
  localparam logic [4:0] CIM_SRC_TS1_C2 = 5'h09;
  localparam logic [4:0] CIM_SRC_TS8_C2 = 5'h10;
  localparam logic [4:0] CIM_SRC_IN1 = 5'h11;
  localparam logic [4:0] CIM_SRC_IN10 = 5'h1a;

  typedef enum logic [3:0] {
    CIM_FN_NONE = 4'h0,
    CIM_FN_RUN_RESET = 4'h1,
    CIM_FN_FORCE_RESET = 4'h2,
    CIM_FN_HOLD = 4'h3,
    CIM_FN_ADVANCE = 4'h4,
    CIM_FN_FIX = 4'h5,
    CIM_FN_MANUAL = 4'h6,
    CIM_FN_LOGIC = 4'h7,
    CIM_FN_PTN2 = 4'h8,
    CIM_FN_PTN3 = 4'h9,
    CIM_FN_PTN4 = 4'ha,
    CIM_FN_PTN5 = 4'hb
  } cim_func_e;

  typedef enum logic {
    CIM_TC_IDLE = 1'b0,
    CIM_TC_ARMED = 1'b1
  } cim_tc_state_e;
endpackage
`default_nettype wire

// *** sim/cim_contact_model.sv ***
// Purpose: Contact switch model driving the ten contact inputs
// Assumes: Requested levels come from the bench
// Notes: Holds every level at least HOLD cycles
`timescale 1ns/1ps
`default_nettype none
module cim_contact_model #(
  parameter int HOLD = 6
) (
  input wire logic clock,
  input wire logic [9:0] want,
  output logic [9:0] contact_input
);
  int held = 0;
  // Contact never changes before its minimum hold time
  always @(posedge clock) begin
    if (want !== contact_input && held >= HOLD) begin
      contact_input <= want;
      held <= 0;
    end else begin
      held <= held + 1;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_contact_input_function_mapper.sv ***
// Purpose: Self-checking bench for the contact input mapper
// Assumes: Short debounce and second counts
// Notes: Registers reached through the plain port
`timescale 1ns/1ps
`default_nettype none
module tb_contact_input_function_mapper;
  import cim_pkg::*;
  logic clock = 0, rst_b = 0, reg_write = 0, reg_read = 0, psv = 0;
  logic [7:0] reg_addr = 8'h00, tsig = 8'h00, tsig2 = 8'h00;
  logic [31:0] reg_wdata = 32'h0, rdata;
  logic [3:0] pf = 4'h0;
  logic [1:0] pc = 2'h0, run, frc, hold_s, step_s, fix, manual_s;
  logic [1:0] autot = 2'h0;
  logic [9:0] want = 10'h000, ci, lgi;
  logic [4:0] sp1, sp2;
  logic pa, pr, tco;
  int err_count = 0, checked = 0, cyc = 0, step_n = 0, tc_n = 0;
  always #4 clock = ~clock;
  cim_contact_model #(.HOLD(6)) model (.clock(clock), .want(want),
    .contact_input(ci));
  cim_contact_input_mapper #(.DEB_CYCLES(4), .SEC_CYCLES(20)) dut (
    .clock(clock), .rst_b(rst_b), .contact_input(ci), .time_signal(tsig),
    .time_signal_ch2(tsig2), .autotune_active(autot), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(rdata), .panel_set_valid(psv), .panel_set_func(pf),
    .panel_set_ch(pc), .panel_accept(pa), .panel_reject(pr),
    .run_active(run), .force_reset(frc), .hold_control(hold_s),
    .program_advance(step_s), .fixed_value_mode(fix),
    .manual_output(manual_s),
    .logic_input(lgi), .start_pattern_ch1(sp1), .start_pattern_ch2(sp2),
    .tc_output(tco));
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (step_s[0] === 1'b1) step_n <= step_n + 1;
    if (tco === 1'b1) tc_n <= tc_n + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc_wait(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(name, rdata, exp);
  endtask
  // Change requested contacts, then wait past hold, sync and filter
  task automatic set_in(logic [9:0] w);
    @(posedge clock);
    want <= w;
    cyc_wait(24);
  endtask
  task automatic panel(logic [3:0] f, logic exp_rej);
    @(posedge clock);
    psv <= 1'b1;
    pf <= f;
    pc <= 2'h1;
    @(posedge clock);
    psv <= 1'b0;
    #1 chk("panel_reject", pr, exp_rej);
    chk("panel_accept", pa, !exp_rej);
  endtask
  task automatic t_reset();
    #1 chk("pattern", sp1, 5'h01);
    chk("run", run, 2'h0);
    rd(CIM_OFF_TC_CFG, 32'h0, "tc_cfg");
    rd(CIM_OFF_TC_PRESET, 32'h0, "preset");
    rd(8'hfc, 32'h0, "unmapped");
  endtask
  task automatic t_run();
    wr(8'h20, 32'h0);
    rd(8'h20, 32'h11, "in1_func");
    set_in(10'h001);
    chk("run_on", run, 2'h1);
    set_in(10'h000);
    chk("run_kept", run, 2'h1);
    set_in(10'h001);
    set_in(10'h000);
    chk("run_off", run, 2'h0);
    set_in(10'h004);
    rd(CIM_OFF_INPUTS, 32'h4, "monitor");
  endtask
  task automatic t_hold_step();
    wr(8'h24, 32'h13);
    wr(8'h28, 32'h14);
    set_in(10'h000);
    set_in(10'h004);
    chk("step_once", step_n, 1);
    set_in(10'h002);
    chk("hold", hold_s, 2'h1);
    set_in(10'h006);
    chk("step_blocked", step_n, 1);
    panel(4'h3, 1'b1);
    panel(4'h6, 1'b0);
    set_in(10'h000);
    chk("hold_off", hold_s, 2'h0);
  endtask
  task automatic t_pattern();
    wr(8'h34, 32'h16);
    wr(CIM_OFF_CTRL, 32'h1);
    wr(8'h30, 32'h1b);
    rd(8'h34, 32'h0, "consumed");
    wr(8'h24, 32'h1a);
    rd(8'h24, 32'h13, "bad_place");
    chk("ptn_zero", sp1, 5'h01);
    set_in(10'h050);
    chk("ptn_five", sp1, 5'h05);
    chk("ptn_ch2", sp2, 5'h01);
  endtask
  task automatic t_tc();
    set_in(10'h000);
    wr(CIM_OFF_TC_CFG, 32'h114);
    wr(CIM_OFF_TC_PRESET, 32'h2);
    set_in(10'h008);
    set_in(10'h000);
    chk("cnt_early", tc_n, 0);
    set_in(10'h008);
    cyc_wait(30);
    chk("cnt_pulse", tc_n, 20);
    wr(CIM_OFF_TC_CFG, 32'h01);
    wr(CIM_OFF_TC_PRESET, 32'h1);
    @(posedge clock);
    tsig <= 8'h01;
    cyc_wait(70);
    chk("tmr_pulse", tc_n, 40);
    wr(CIM_OFF_TC_CFG, 32'h09);
    @(posedge clock);
    tsig2 <= 8'h01;
    cyc_wait(70);
    chk("tmr_ch2", tc_n, 60);
    wr(CIM_OFF_TC_CFG, 32'h0);
    set_in(10'h000);
    set_in(10'h008);
    cyc_wait(50);
    chk("src_none", tc_n, 60);
  endtask
  // Level functions, autotune block, fixed mode and unbinding
  task automatic t_levels();
    wr(8'h2c, 32'h07);
    wr(8'h44, 32'h15);
    wr(8'h40, 32'h32);
    wr(8'h38, 32'h16);
    set_in(10'h208);
    chk("fix", fix, 2'h1);
    chk("logic", lgi, 10'h008);
    @(posedge clock);
    autot <= 2'h1;
    set_in(10'h348);
    chk("manual_at", manual_s, 2'h0);
    chk("force", frc, 2'h3);
    chk("ptn_fix", sp1, 5'h01);
    @(posedge clock);
    autot <= 2'h0;
    cyc_wait(2);
    chk("manual_on", manual_s, 2'h1);
    wr(8'h2c, 32'h0);
    wr(8'h40, 32'h0);
    set_in(10'h000);
    chk("logic_off", lgi, 10'h000);
    chk("force_kept", frc, 2'h3);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    cyc_wait(8);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset();
    t_run();
    t_hold_step();
    t_pattern();
    t_tc();
    t_levels();
    print_verdict();
  end
endmodule
`default_nettype wire
